// [rtl/lsag_addr_adder.sv]
`timescale 1ns/1ps

// Base plus or minus offset, 32-bit wrap with no overflow flag
module lsag_addr_adder (
  // Operands
  input wire logic [31:0] base_value,
  input wire logic [31:0] offset,
  // Direction: 1 adds, 0 subtracts
  input wire logic up,
  // Result
  output logic [31:0] result
);

  // Adder, purely combinational
  always_comb
  begin
    // direction bit picks add or subtract
    if (up)
      result = 32'(base_value + offset);
    else
      result = 32'(base_value - offset);
  end

endmodule : lsag_addr_adder

// [rtl/lsag_addr_gen.sv]
`timescale 1ns/1ps

// Function
// - post-index: base is address, then writeback
// - index bit set: offset applied first
// - direction bit adds or subtracts offset
// - size bit: byte when set, else word
// - post-index writeback bit means unprivileged access
// - pre-index writeback bit updates base register
// - load bit: load when set, else store
// - bit 25 clear: 12-bit unsigned immediate
// - register offset equals left shift by zero
// - scaled form: amount 11:7, type 6:5
// - logical left uses amount 0 to 31
// - right shifts: zero field means 32
// - rotate zero field selects extend form
// - zero immediate offset gives base unchanged
// - program counter base reads address plus eight
// - unprivileged variants only post-indexed forms
// - preload hint only takes offset forms; other forms are flagged in form_illegal, not refused
// - base writeback only when condition passes
// - shift type two-bit decode
// - shift by 32 gives zero or sign
// - extend form inserts carry at bit 31
module lsag_addr_gen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Decode request
  input wire logic in_valid,
  input wire logic [31:0] instr,
  input wire logic [31:0] instr_addr,
  // Register values read for this instruction
  input wire logic [31:0] base_value,
  input wire logic [31:0] index_value,
  // Flags and class of the instruction
  input wire logic carry_flag,
  input wire logic cond_pass,
  input wire logic is_preload,
  // Result to memory stage and writeback
  output logic out_valid,
  output logic [31:0] mem_addr,
  output logic [31:0] wb_value,
  output logic wb_en,
  output logic byte_access,
  output logic load,
  output logic unpriv,
  // Diagnostic flags, also mirrored in status
  output logic form_illegal,
  output logic index_pc,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  // Register port read data
  output logic [31:0] reg_rdata
);

  // Whole state of the block, registered as one word
  typedef struct packed {
    // Request seen last cycle; high for one cycle per request
    logic out_valid;
    // Access address for the memory stage
    logic [31:0] mem_addr;
    // New base value, meaningful only with wb_en
    logic [31:0] wb_value;
    // Base writeback strobe, one cycle with out_valid
    logic wb_en;
    // Access size: byte when set
    logic byte_access;
    // Transfer direction: load when set
    logic load;
    // User-level access for the post-indexed variants
    logic unpriv;
    // Preload used with an indexed form
    logic form_illegal;
    // Index field named the program counter
    logic index_pc;
    // Control bit: keep illegal forms off the register file
    logic ctrl_suppress;
    // Requests seen since the last clear; wraps silently
    logic [15:0] decode_count;
    // Copies of the last request's flags for the status register
    logic last_illegal;
    logic last_index_pc;
    // Read data, valid the cycle after a read only
    logic [31:0] rd_data;
  } lsag_state_t;

  // True when a register field names the program counter
  // Shared by the base select and the index flag so both decode alike
  function automatic logic names_pc(input logic [3:0] reg_num);
    names_pc = (reg_num == lsag_pkg::PC_REG_NUM);
  endfunction : names_pc

  // Current and next state
  // One register holds everything, so reset and update stay in step
  lsag_state_t state;
  lsag_state_t next_state;

  // Decoded instruction fields
  // Form bit: immediate when clear, index register when set
  logic reg_form;
  // Index position: offset applied before the access when set
  logic index_pos;
  // Direction: add when set, subtract when clear
  logic up;
  // Writeback bit, whose meaning depends on the index position
  logic wb_bit;
  // Base and index register numbers
  logic [3:0] base_num;
  logic [3:0] index_num;
  // Immediate, overlapping the shift fields below
  logic [11:0] imm_field;
  // Shift amount and type of the scaled form
  logic [4:0] shift_amount;
  logic [1:0] shift_type;

  // Datapath values
  // Base after the program counter substitution
  logic [31:0] base_eff;
  // Immediate or shifted index
  logic [31:0] offset;
  // Sum or difference of base and offset
  logic [31:0] computed;

  // Form checks
  // Post-indexed with writeback bit: user-level access
  logic is_unpriv_form;
  // Preload with a pre- or post-indexed form
  logic preload_bad;
  // The form asks for a base update
  logic writes_back;

  // Field extraction
  // Fields overlap between forms; the shifter picks the one that applies
  // Single-bit controls
  assign reg_form = instr[lsag_pkg::BIT_REG_FORM];
  assign index_pos = instr[lsag_pkg::BIT_INDEX_POS];
  assign up = instr[lsag_pkg::BIT_UP];
  assign wb_bit = instr[lsag_pkg::BIT_WB];
  // Register numbers and immediate
  assign base_num = instr[lsag_pkg::BASE_LSB +: lsag_pkg::FIELD_REG_W];
  assign index_num = instr[lsag_pkg::INDEX_LSB +: lsag_pkg::FIELD_REG_W];
  assign imm_field = instr[lsag_pkg::IMM_LSB +: lsag_pkg::FIELD_IMM_W];
  assign shift_amount = instr[lsag_pkg::SHAMT_LSB +: lsag_pkg::FIELD_SHAMT_W];
  assign shift_type = instr[lsag_pkg::STYPE_LSB +: lsag_pkg::FIELD_STYPE_W];

  // Base operand selection
  // A program counter base is never read from the register file
  // Applied in every form, so a post-indexed access also sees the read-ahead
  always_comb
  begin
    // program counter reads ahead by eight
    if (names_pc(base_num))
      base_eff = 32'(instr_addr + lsag_pkg::PC_READ_AHEAD);
    else
      base_eff = base_value;
  end

  // Offset former
  // Both offset kinds are formed; the form bit picks one
  // The shift fields are meaningless in immediate form and ignored there
  lsag_index_shifter u_shifter (
    .index_value(index_value),
    .carry_flag(carry_flag),
    .reg_form(reg_form),
    .imm_field(imm_field),
    .shift_amount(shift_amount),
    .shift_type(shift_type),
    .offset(offset)
  );

  // Base plus or minus offset
  // One adder feeds address and writeback, so the two agree in pre-indexed forms
  lsag_addr_adder u_adder (
    .base_value(base_eff),
    .offset(offset),
    .up(up),
    .result(computed)
  );

  // Form legality
  // Only preload misuse is caught; other reserved encodings pass through
  // The class input is trusted; the opcode bits are not rechecked here
  always_comb
  begin
    // post-index with writeback bit is unprivileged
    // unprivileged exists only in post-index encodings
    is_unpriv_form = !index_pos && wb_bit && !is_preload;
    // preload with any indexed form is flagged
    preload_bad = is_preload && (!index_pos || wb_bit);
    // pre-index updates only with writeback bit
    writes_back = !index_pos || wb_bit;
  end

  // Next state: decode result and register port
  // Default holds every field; the branches below override
  always_comb
  begin
    next_state = state;
    // Valid follows the request by exactly one cycle
    next_state.out_valid = in_valid;
    if (in_valid)
    begin
      // every result field loads in one cycle
      // post-index addresses with the base itself
      // index bit set uses the computed address
      // zero offset leaves the base as the address
      if (index_pos)
        next_state.mem_addr = computed;
      else
        next_state.mem_addr = base_eff;
      // Writeback value is the computed address in every form
      next_state.wb_value = computed;
      // writeback gated by condition pass
      // A preload never updates a register, legal or not
      next_state.wb_en = cond_pass && writes_back && !is_preload;
      // Policy bit stays visible to software although preload already blocks
      // Illegal forms may be kept away from the register file
      if (preload_bad && state.ctrl_suppress)
        next_state.wb_en = 1'b0;
      next_state.byte_access = instr[lsag_pkg::BIT_BYTE];
      next_state.load = instr[lsag_pkg::BIT_LOAD];
      next_state.unpriv = is_unpriv_form;
      // Illegal preload form is flagged, never refused
      next_state.form_illegal = preload_bad;
      // program counter index only flagged, result undefined
      next_state.index_pc = reg_form && names_pc(index_num);
      // Status copies hold until the next request
      next_state.last_illegal = preload_bad;
      next_state.last_index_pc = reg_form && names_pc(index_num);
    end
    else
    begin
      // Idle cycle: strobe-like outputs drop, data hold
      // Data fields hold so a stalled stage still sees the last result
      next_state.wb_en = 1'b0;
    end

    // Register writes
    if (reg_write)
    begin
      if (reg_addr == lsag_pkg::CTRL_OFFSET)
      begin
        // Only the suppress bit is kept; other bits are dropped
        next_state.ctrl_suppress = reg_wdata[lsag_pkg::CTRL_SUPPRESS_BIT];
      end
      else if (reg_addr == lsag_pkg::STATUS_OFFSET)
      begin
        // Writing status clears the decode counter
        next_state.decode_count = lsag_pkg::COUNT_RESET;
      end
      // Unmapped offsets fall through and change nothing
    end

    // Decode counter, a clear in the same cycle as a request leaves it at one
    // Wraps at 16 bits, so software must sample it often enough
    if (in_valid)
    begin
      if (reg_write && reg_addr == lsag_pkg::STATUS_OFFSET)
        next_state.decode_count = 16'h0001;
      else
        next_state.decode_count = 16'(state.decode_count + 16'h0001);
    end

    // Register reads, data valid only in the following cycle
    // Zero default keeps the read bus quiet between reads
    next_state.rd_data = lsag_pkg::WORD_RESET;
    if (reg_read)
    begin
      if (reg_addr == lsag_pkg::CTRL_OFFSET)
      begin
        // Only bit 0 is implemented
        next_state.rd_data[lsag_pkg::CTRL_SUPPRESS_BIT] = state.ctrl_suppress;
      end
      else if (reg_addr == lsag_pkg::STATUS_OFFSET)
      begin
        // Count, then the two last-request flags above it
        next_state.rd_data[lsag_pkg::STATUS_COUNT_LSB +: 16] = state.decode_count;
        next_state.rd_data[lsag_pkg::STATUS_ILLEGAL_BIT] = state.last_illegal;
        next_state.rd_data[lsag_pkg::STATUS_INDEX_PC_BIT] = state.last_index_pc;
      end
      else
      begin
        // Unmapped offsets read as zero
        next_state.rd_data = lsag_pkg::WORD_RESET;
      end
    end
  end

  // State register, synchronous reset
  // No asynchronous path, so reset needs a running clock
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      // Result outputs clear
      state.out_valid <= 1'b0;
      state.mem_addr <= lsag_pkg::WORD_RESET;
      state.wb_value <= lsag_pkg::WORD_RESET;
      state.wb_en <= 1'b0;
      state.byte_access <= 1'b0;
      state.load <= 1'b0;
      state.unpriv <= 1'b0;
      state.form_illegal <= 1'b0;
      state.index_pc <= 1'b0;
      // Suppress is on until software clears it
      state.ctrl_suppress <= lsag_pkg::CTRL_SUPPRESS_RESET;
      // Counter and last-request flags
      state.decode_count <= lsag_pkg::COUNT_RESET;
      state.last_illegal <= 1'b0;
      state.last_index_pc <= 1'b0;
      // Read bus idles at zero
      state.rd_data <= lsag_pkg::WORD_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register
  // Decode result
  assign out_valid = state.out_valid;
  assign mem_addr = state.mem_addr;
  assign wb_value = state.wb_value;
  assign wb_en = state.wb_en;
  assign byte_access = state.byte_access;
  assign load = state.load;
  assign unpriv = state.unpriv;
  // Diagnostic flags
  assign form_illegal = state.form_illegal;
  assign index_pc = state.index_pc;
  // Register port read data
  assign reg_rdata = state.rd_data;

endmodule : lsag_addr_gen

// [rtl/lsag_index_shifter.sv]
`timescale 1ns/1ps

// Offset former: immediate, or shifted or rotated index register
module lsag_index_shifter (
  // Operands
  input wire logic [31:0] index_value,
  input wire logic carry_flag,
  // Decoded fields
  input wire logic reg_form,
  input wire logic [11:0] imm_field,
  input wire logic [4:0] shift_amount,
  input wire logic [1:0] shift_type,
  // Result
  output logic [31:0] offset
);

  // Doubled index; a rotate ORs a right shift of the low half with a left shift of the high half
  logic [63:0] doubled;
  assign doubled = {index_value, index_value};

  // Offset selection, purely combinational
  always_comb
  begin
    offset = 32'h0000_0000;
    if (!reg_form)
    begin
      offset = {20'h00000, imm_field};
    end
    else
    begin
      case (shift_type)
        lsag_pkg::LSAG_LOGICAL_LEFT:
        begin
          // register form is left by zero
          offset = index_value << shift_amount;
        end
        lsag_pkg::LSAG_LOGICAL_RIGHT:
        begin
          if (shift_amount == 5'h00)
            offset = 32'h0000_0000;
          else
            offset = index_value >> shift_amount;
        end
        lsag_pkg::LSAG_ARITHMETIC_RIGHT:
        begin
          // sign fill on shift by 32
          if (shift_amount == 5'h00)
            offset = {32{index_value[31]}};
          else
            offset = 32'($signed(index_value) >>> shift_amount);
        end
        default:
        begin
          if (shift_amount == 5'h00)
            offset = {carry_flag, index_value[31:1]};
          else
            offset = doubled[31:0] >> shift_amount | doubled[63:32] << (6'd32 - {1'b0, shift_amount});
        end
      endcase
    end
  end

endmodule : lsag_index_shifter

// [rtl/lsag_pkg.sv]
package lsag_pkg;

  // Instruction bit positions of the addressing fields
  localparam int BIT_REG_FORM = 25;
  localparam int BIT_INDEX_POS = 24;
  localparam int BIT_UP = 23;
  localparam int BIT_BYTE = 22;
  localparam int BIT_WB = 21;
  localparam int BIT_LOAD = 20;
  localparam int BASE_LSB = 16;
  localparam int INDEX_LSB = 0;
  localparam int IMM_LSB = 0;
  localparam int SHAMT_LSB = 7;
  localparam int STYPE_LSB = 5;
  localparam int FIELD_REG_W = 4;
  localparam int FIELD_IMM_W = 12;
  localparam int FIELD_SHAMT_W = 5;
  localparam int FIELD_STYPE_W = 2;

  // Register number of the program counter
  localparam logic [3:0] PC_REG_NUM = 4'hF;
  // The program counter reads as the instruction address plus this
  localparam logic [31:0] PC_READ_AHEAD = 32'h0000_0008;

  // Shift type encodings of the scaled register form
  typedef enum logic [1:0] {
    LSAG_LOGICAL_LEFT = 2'h0,
    LSAG_LOGICAL_RIGHT = 2'h1,
    LSAG_ARITHMETIC_RIGHT = 2'h2,
    LSAG_ROTATE_RIGHT = 2'h3
  } lsag_shift_t;

  // Register port offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  // Control register field: suppress writeback on an illegal form
  localparam int CTRL_SUPPRESS_BIT = 0;
  // Status register fields
  localparam int STATUS_COUNT_LSB = 0;
  localparam int STATUS_ILLEGAL_BIT = 16;
  localparam int STATUS_INDEX_PC_BIT = 17;

  // Reset values
  localparam logic CTRL_SUPPRESS_RESET = 1'b1;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

endpackage : lsag_pkg

// [verif/load_store_address_gen_tb_top.sv]
`timescale 1ns/1ps

// Self-checking bench: reference model with a queue of expected results
module load_store_address_gen_tb_top;
  logic core_clk, rst, in_valid, carry_flag, cond_pass, is_preload, out_valid, wb_en, byte_access;
  logic load, unpriv, form_illegal, index_pc, reg_write, reg_read, load_en;
  logic [31:0] instr, instr_addr, base_value, index_value, mem_addr, wb_value, reg_wdata, reg_rdata;
  logic [31:0] load_data, ins;
  logic [7:0] reg_addr;
  logic [3:0] load_num;
  logic [31:0] m_regs [16];
  logic [31:0] exp_q [$];
  logic m_ill;
  integer seed = 40216;
  int n_fail, check_count, cycles, n_req, i, t, a;
  int amts [3] = '{0, 1, 31};

  lsag_addr_gen dut (.core_clk, .rst, .in_valid, .instr, .instr_addr, .base_value, .index_value, .carry_flag,
    .cond_pass, .is_preload, .out_valid, .mem_addr, .wb_value, .wb_en, .byte_access, .load, .unpriv,
    .form_illegal, .index_pc, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
  lsag_regfile_model rf (.core_clk, .load_en, .load_num, .load_data, .in_valid, .instr, .base_value,
    .index_value, .out_valid, .wb_en, .wb_value);

  always #5 core_clk = ~core_clk;

  task check(logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task results();
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  // Offset from the index register by shift type; zero amounts are the special forms
  function automatic logic [31:0] shift_index(logic [31:0] v, logic [31:0] s, logic c);
    int n;
    n = s[11:7];
    case (s[6:5])
      2'h0: return v << n;
      2'h1: return (n == 0) ? 32'h0 : v >> n;
      2'h2: return (n == 0) ? {32{v[31]}} : 32'($signed(v) >>> n);
      default: return (n == 0) ? {c, v[31:1]} : (v >> n) | (v << (32 - n));
    endcase
  endfunction : shift_index

  // One request; expectations are worked out before driving
  task issue(logic [31:0] s, logic [31:0] pc, logic c, logic cp, logic pl, bit gap);
    logic [31:0] base, ofs, sum;
    logic wbe;
    base = (s[19:16] == 4'hF) ? pc + 32'h8 : m_regs[s[19:16]];
    ofs = s[25] ? shift_index(m_regs[s[3:0]], s, c) : {20'h0, s[11:0]};
    sum = s[23] ? base + ofs : base - ofs;
    wbe = cp && (!s[24] || s[21]) && !pl;
    m_ill = pl && (!s[24] || s[21]);
    exp_q.push_back(s[24] ? sum : base);
    exp_q.push_back(sum);
    exp_q.push_back({26'h0, wbe, s[22], s[20], !s[24] && s[21] && !pl, m_ill, s[25] && s[3:0] == 4'hF});
    if (wbe)
      m_regs[s[19:16]] = sum;
    n_req++;
    @(posedge core_clk);
    instr <= s;
    instr_addr <= pc;
    carry_flag <= c;
    cond_pass <= cp;
    is_preload <= pl;
    in_valid <= 1'b1;
    if (gap)
    begin
      @(posedge core_clk);
      in_valid <= 1'b0;
    end
  endtask : issue

  task reg_wr(logic [7:0] ad, logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : reg_wr

  task reg_rd(logic [7:0] ad, logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask : reg_rd

  // Compare every result against the queue; also bounds the run
  always @(posedge core_clk)
  begin
    if (!rst && out_valid === 1'b1)
    begin
      check(mem_addr, exp_q.pop_front());
      check(wb_value, exp_q.pop_front());
      check({26'h0, wb_en, byte_access, load, unpriv, form_illegal, index_pc}, exp_q.pop_front());
    end
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      results();
    end
  end

  initial
  begin
    {core_clk, in_valid, carry_flag, cond_pass, is_preload, reg_write, reg_read, load_en} = '0;
    {instr, instr_addr, reg_wdata, load_data, reg_addr, load_num} = '0;
    rst = 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    reg_rd(8'h00, 32'h1);
    reg_rd(8'h04, 32'h0);
    reg_rd(8'h08, 32'h0);
    // Near-wrap base and negative index give the awkward arithmetic
    for (i = 0; i < 16; i++)
    begin
      m_regs[i] = (i == 1) ? 32'hFFFF_FFF0 : (i == 2) ? 32'h8000_00F1 : $random(seed);
      @(posedge core_clk);
      load_en <= 1'b1;
      load_num <= 4'(i);
      load_data <= m_regs[i];
    end
    @(posedge core_clk);
    load_en <= 1'b0;
    for (t = 0; t < 4; t++)
      for (a = 0; a < 3; a++)
      begin
        ins = 32'hE791_0002;
        ins[11:7] = 5'(amts[a]);
        ins[6:5] = 2'(t);
        issue(ins, 32'h0, 1'b1, 1'b1, 1'b0, 1'b1);
      end
    issue(32'hE59F_0000, 32'h0000_1000, 1'b0, 1'b1, 1'b0, 1'b1);
    issue(32'hE591_0000, 32'h0, 1'b0, 1'b1, 1'b0, 1'b1);
    // Random forms; index register never the program counter
    repeat (200)
    begin
      ins = $random(seed);
      ins[4] = ins[4] && !ins[25];
      ins[3:0] = (ins[25] && ins[3:0] == 4'hF) ? 4'hE : ins[3:0];
      issue(ins, $random(seed), 1'($random(seed)), 1'($random(seed)), 2'($random(seed)) == 2'h0, 1'b1);
    end
    reg_rd(8'h04, {14'h0, 1'b0, m_ill, n_req[15:0]});
    reg_wr(8'h04, 32'h0);
    reg_wr(8'h0C, 32'hFFFF_FFFF);
    reg_rd(8'h0C, 32'h0);
    reg_wr(8'h00, 32'h0);
    reg_rd(8'h00, 32'h0);
    // Back-to-back burst; condition failed so no writeback hazard
    // Bit 3 cleared so the index never names the program counter
    for (i = 0; i < 20; i++)
      issue($random(seed) & 32'hFFFF_F7E7, $random(seed), 1'($random(seed)), 1'b0, 1'b0, i == 19);
    reg_rd(8'h04, {14'h0, 1'b0, m_ill, 16'h14});
    repeat (3) @(posedge core_clk);
    check(exp_q.size(), 0);
    results();
  end
endmodule : load_store_address_gen_tb_top

// [verif/lsag_addr_gen_sva.sv]
`timescale 1ns/1ps

// Watches the request and result ports of the address generator
module lsag_addr_gen_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Request
  input wire logic in_valid,
  input wire logic [31:0] instr,
  input wire logic [31:0] base_value,
  input wire logic cond_pass,
  input wire logic is_preload,
  // Result
  input wire logic out_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] wb_value,
  input wire logic wb_en,
  input wire logic byte_access,
  input wire logic load,
  input wire logic unpriv
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Base plus immediate, captured so the offset form can be checked a cycle on
  logic [31:0] imm_sum;
  always_ff @(posedge core_clk)
  begin
    imm_sum <= base_value + {20'h0, instr[11:0]};
  end

  AST_VALID_NEXT: assert property (in_valid |=> out_valid)
    else $error("result missing after request");
  AST_NO_EXTRA: assert property (!in_valid |=> !out_valid && !wb_en)
    else $error("result without request");
  AST_LOAD_BIT: assert property (in_valid |=> load == $past(instr[20]))
    else $error("load indication wrong");
  AST_BYTE_BIT: assert property (in_valid |=> byte_access == $past(instr[22]))
    else $error("byte indication wrong");
  AST_COND_WB: assert property (in_valid && !cond_pass |=> !wb_en)
    else $error("writeback on failed condition");
  AST_OFFSET_KEEP: assert property (in_valid && instr[24] && !instr[21] |=> !wb_en)
    else $error("offset form wrote base");
  AST_POST_ADDR: assert property (in_valid && !instr[24] && instr[19:16] != 4'hF |=> mem_addr == $past(base_value))
    else $error("post-index address not base");
  AST_POST_WB: assert property (in_valid && !instr[24] && cond_pass && !is_preload |=> wb_en)
    else $error("post-index writeback missing");
  AST_UNPRIV: assert property (in_valid && !is_preload |=> unpriv == ($past(instr[21]) && !$past(instr[24])))
    else $error("unprivileged indication wrong");
  AST_IMM_OFS: assert property (in_valid && instr[25:23] == 3'h3 && instr[19:16] != 4'hF |=> mem_addr == imm_sum)
    else $error("immediate offset address wrong");
  AST_PRE_WB: assert property (in_valid && instr[24] |=> wb_value == mem_addr)
    else $error("pre-index writeback value wrong");

  // Main scenarios reached
  C_POST_WB: cover property (in_valid && !instr[24] && cond_pass && !is_preload);
  C_PRELOAD: cover property (in_valid && is_preload);
  C_EXTEND: cover property (in_valid && instr[25] && instr[6:5] == 2'h3 && instr[11:7] == 5'h0);
endmodule : lsag_addr_gen_sva

bind lsag_addr_gen lsag_addr_gen_sva u_sva (.core_clk, .rst, .in_valid, .instr, .base_value, .cond_pass,
  .is_preload, .out_valid, .mem_addr, .wb_value, .wb_en, .byte_access, .load, .unpriv);

// [verif/lsag_regfile_model.sv]
`timescale 1ns/1ps

// Core register file facing the generator: two read ports and base writeback
module lsag_regfile_model (
  // Clock
  input wire logic core_clk,
  // Content loading by the bench
  input wire logic load_en,
  input wire logic [3:0] load_num,
  input wire logic [31:0] load_data,
  // Read side
  input wire logic in_valid,
  input wire logic [31:0] instr,
  output logic [31:0] base_value,
  output logic [31:0] index_value,
  // Writeback side
  input wire logic out_valid,
  input wire logic wb_en,
  input wire logic [31:0] wb_value
);
  logic [31:0] regs [16];
  logic [3:0] base_num_q;
  // Reads are combinational; no forwarding, so back-to-back writeback is a hazard
  assign base_value = regs[instr[19:16]];
  assign index_value = regs[instr[3:0]];
  // Writeback lands at the edge closing the result cycle
  always @(posedge core_clk)
  begin
    if (in_valid)
      base_num_q <= instr[19:16];
    if (load_en)
      regs[load_num] <= load_data;
    else if (out_valid && wb_en)
      regs[base_num_q] <= wb_value;
  end
endmodule : lsag_regfile_model
